// *** logic/rcm_pkg.sv ***
// Purpose: Constants and types for the reference clock monitor.
// Assumes: 100 MHz clock, 16-bit register port, word offsets of own choice.
// Notes: Period limits and multi-period counts are in 10 ns units; time base counts in reference cycles.
//
// Operation
// [RQ1] One monitor per reference, period and frequency
// [RQ2] Status register reports, mask register ignores checks
// [RQ3] Period limits counted in 10 ns clocks
// [RQ4] Per-reference lower and upper period limit registers
// [RQ5] 8 kHz defaults: upper 2e4a, lower 335c
// [RQ6] 1.544 MHz defaults: upper 002b, lower 0055
// [RQ7] 2.048 MHz defaults: upper 0025, lower 003b
// [RQ8] 4.096 MHz defaults: upper 0011, lower 001e
// [RQ9] 8.192 MHz defaults: upper 0007, lower 000f
// [RQ10] 16.384/19.44 MHz: upper 0002, lower 0008/0007
// [RQ11] Fail beyond far limit, recover inside near
// [RQ12] Decide only after two consecutive measurements
// [RQ13] Time base count split in two 16-bit halves
// [RQ14] Time base defaults to ten seconds
// [RQ15] One shared set of near/far limits
// [RQ16] Limit enable clear selects built-in Stratum 3 values
// [RQ17] Far upper, near upper, nominal defaults
// [RQ18] Near lower, far lower defaults
// [RQ19] Fast lock bypasses phase speed limiter
// [RQ20] Semi-fast lock keeps the limiter active
// [RQ21] Freerun never locks to a reference
// [RQ22] Software never combines freerun with fast lock
// [RQ23] Auto frequency detect unless override enabled
// [RQ24] Fail bit follows unmasked failing checks
`default_nettype none
package rcm_pkg;
  ////////////////////////////////////////////////////////////////////////
  // Frequency codes
  typedef enum logic [2:0] {
    RCM_F8K = 3'h0, RCM_F1544 = 3'h1, RCM_F2048 = 3'h2, RCM_F4096 = 3'h3,
    RCM_F8192 = 3'h4, RCM_F16384 = 3'h5, RCM_F1944 = 3'h6, RCM_FNONE = 3'h7
  } rcm_freq_e;
  // Register port bundle
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } rcm_bus_s;
  // Register word offsets
  localparam logic [7:0] RCM_LOOP_CTRL = 8'h00;
  localparam logic [7:0] RCM_BW_CTRL = 8'h01;
  localparam logic [7:0] RCM_REF_CHG = 8'h02;
  localparam logic [7:0] RCM_STATUS = 8'h03;
  localparam logic [7:0] RCM_MASK = 8'h04;
  localparam logic [7:0] RCM_FREQ_PROG = 8'h05;
  localparam logic [7:0] RCM_FREQ_STAT = 8'h06;
  localparam logic [7:0] RCM_LOW_BASE = 8'h10;   // ref n lower limit at +n
  localparam logic [7:0] RCM_UPP_BASE = 8'h14;   // ref n upper limit at +n
  localparam logic [7:0] RCM_TB_BASE = 8'h18;    // ref n low at +2n, high +2n+1
  localparam logic [7:0] RCM_LIM_BASE = 8'h20;   // nu,fu,nl,fl low/high pairs
  // Control fields
  localparam int RCM_FREQ_OVR_BIT = 1;
  localparam int RCM_LIM_EN_BIT = 2;
  localparam int RCM_SEMI_FAST_BIT = 3;
  localparam int RCM_FAST_BIT = 13;
  localparam int RCM_FREERUN_BIT = 0;
  // Stratum 3 multi-period values
  localparam logic [31:0] RCM_S3_FAR_UP = 32'h3b9a9de8;   // [RQ17]
  localparam logic [31:0] RCM_S3_NEAR_UP = 32'h3b9aa346;  // [RQ17]
  localparam logic [31:0] RCM_S3_NOMINAL = 32'h3b9ac9ff;  // [RQ17]
  localparam logic [31:0] RCM_S3_NEAR_LO = 32'h3b9af0b8;  // [RQ18]
  localparam logic [31:0] RCM_S3_FAR_LO = 32'h3b9af616;   // [RQ18]
  // Ten second base in 8 kHz reference cycles
  localparam int RCM_TB_SECONDS = 10;
  localparam int RCM_REF8K_HZ = 8000;
  localparam logic [31:0] RCM_TB_DEFAULT = 32'(RCM_TB_SECONDS * RCM_REF8K_HZ); // [RQ14]
  // Single period defaults, 8 kHz to 19.44 MHz
  localparam logic [15:0] RCM_UP_8K = 16'h2e4a;   // [RQ5]
  localparam logic [15:0] RCM_LO_8K = 16'h335c;   // [RQ5]
  localparam logic [15:0] RCM_UP_1544 = 16'h002b; // [RQ6]
  localparam logic [15:0] RCM_LO_1544 = 16'h0055; // [RQ6]
  localparam logic [15:0] RCM_UP_2048 = 16'h0025; // [RQ7]
  localparam logic [15:0] RCM_LO_2048 = 16'h003b; // [RQ7]
  localparam logic [15:0] RCM_UP_4096 = 16'h0011; // [RQ8]
  localparam logic [15:0] RCM_LO_4096 = 16'h001e; // [RQ8]
  localparam logic [15:0] RCM_UP_8192 = 16'h0007; // [RQ9]
  localparam logic [15:0] RCM_LO_8192 = 16'h000f; // [RQ9]
  localparam logic [15:0] RCM_UP_16M = 16'h0002;  // [RQ10]
  localparam logic [15:0] RCM_LO_16384 = 16'h0008; // [RQ10]
  localparam logic [15:0] RCM_LO_1944 = 16'h0007;  // [RQ10]
  // Detector period windows, clocks per period
  localparam logic [15:0] RCM_DET_1544 = 16'h0050;
  localparam logic [15:0] RCM_DET_2048 = 16'h0038;
  localparam logic [15:0] RCM_DET_4096 = 16'h001c;
  localparam logic [15:0] RCM_DET_8192 = 16'h000e;
  localparam logic [15:0] RCM_DET_16384 = 16'h0007;
  localparam logic [15:0] RCM_DET_1944 = 16'h0006;
  localparam logic [15:0] RCM_DET_8K = 16'h2000;
  localparam logic [15:0] RCM_LOSS = 16'hffff;
endpackage
`default_nettype wire

// *** logic/rcm_period_chk.sv ***
// Purpose: Single-period check and frequency detect for one reference.
// Assumes: Reference input already synchronous to clock_i.
// Notes: Limits in 10 ns clocks; a lost reference fails on counter saturation.
`default_nettype none
module rcm_period_chk
  import rcm_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ref_i,
  input wire logic [15:0] low_lim_i,
  input wire logic [15:0] up_lim_i,
  output logic rise_o,
  output logic fail_o,
  output rcm_pkg::rcm_freq_e freq_o
);
  import rcm_pkg::*;
  logic ref_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic fail_q;
  rcm_freq_e freq_q;
  rcm_freq_e det_w;
  wire rise_w = ref_i & ~ref_q;
  wire lost_w = (cnt_q == RCM_LOSS);
  // Period out of window: shorter than upper or beyond lower
  wire bad_w = (cnt_q < up_lim_i) | (cnt_q > low_lim_i); // [RQ3]
  assign cnt_d = rise_w ? 16'h0001 : (lost_w ? cnt_q : cnt_q + 16'h0001);
  assign rise_o = rise_w;
  assign fail_o = fail_q;
  assign freq_o = freq_q;
  // Coarse rate classification from the measured period
  assign det_w = (cnt_q <= RCM_DET_1944) ? RCM_F1944 :
                 (cnt_q <= RCM_DET_16384) ? RCM_F16384 :
                 (cnt_q <= RCM_DET_8192) ? RCM_F8192 :
                 (cnt_q <= RCM_DET_4096) ? RCM_F4096 :
                 (cnt_q <= RCM_DET_2048) ? RCM_F2048 :
                 (cnt_q <= RCM_DET_1544) ? RCM_F1544 :
                 (cnt_q >= RCM_DET_8K) ? RCM_F8K : RCM_FNONE;
  ////////////////////////////////////////////////////////////////////////
  // Period counter and per-edge verdict
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ref_q <= 1'b0;
      cnt_q <= 16'h0000;
      fail_q <= 1'b0;
      freq_q <= RCM_FNONE;
    end
    else
    begin
      ref_q <= ref_i;
      cnt_q <= cnt_d;
      if (rise_w)
      begin
        fail_q <= bad_w; // [RQ1]
        freq_q <= det_w; // [RQ23]
      end
      else if (lost_w)
      begin
        fail_q <= 1'b1;
        freq_q <= RCM_FNONE;
      end
    end
  end
  // Lost reference must be flagged one cycle after saturation
  a_loss_flags: assert property (@(posedge clock_i) disable iff (!nrst_i) // [RQ1]
    lost_w && !rise_w |=> fail_q)
    else $error("lost reference not flagged");
endmodule
`default_nettype wire

// *** logic/rcm_multi_chk.sv ***
// Purpose: Multi-period frequency check with hysteresis for one reference.
// Assumes: rise_i is a one-cycle pulse per reference rising edge.
// Notes: Measures clocks elapsed over a count of reference cycles.
`default_nettype none
module rcm_multi_chk
  import rcm_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic rise_i,
  input wire logic [31:0] tb_i,
  input wire logic [31:0] near_up_i,
  input wire logic [31:0] far_up_i,
  input wire logic [31:0] near_lo_i,
  input wire logic [31:0] far_lo_i,
  output logic fail_o
);
  import rcm_pkg::*;
  logic [31:0] cyc_q;
  logic [31:0] clk_q;
  logic far_q;
  logic near_q;
  logic fail_q;
  wire done_w = rise_i & (cyc_q + 32'h1 >= tb_i);
  // Outer band fails, inner band passes; between is grey
  wire far_w = (clk_q < far_up_i) | (clk_q > far_lo_i);
  wire near_w = (clk_q >= near_up_i) & (clk_q <= near_lo_i);
  assign fail_o = fail_q;
  ////////////////////////////////////////////////////////////////////////
  // Window counters and two-in-a-row decision
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cyc_q <= 32'h0;
      clk_q <= 32'h0;
      far_q <= 1'b0;
      near_q <= 1'b0;
      fail_q <= 1'b0;
    end
    else
    begin
      clk_q <= done_w ? 32'h1 : clk_q + 32'h1; // [RQ13]
      if (rise_i)
        cyc_q <= done_w ? 32'h0 : cyc_q + 32'h1;
      if (done_w)
      begin
        far_q <= far_w;
        near_q <= near_w;
        if (far_w && far_q)
          fail_q <= 1'b1; // [RQ11] [RQ12]
        else if (near_w && near_q)
          fail_q <= 1'b0; // [RQ11] [RQ12]
      end
    end
  end
  a_grey_holds: assert property (@(posedge clock_i) disable iff (!nrst_i) // [RQ11]
    done_w && !far_w && !near_w |=> $stable(fail_q))
    else $error("grey zone changed the verdict");
  a_two_far: assert property (@(posedge clock_i) disable iff (!nrst_i) // [RQ12]
    done_w && far_w && !far_q && !fail_q |=> !fail_q)
    else $error("failed after one measurement");
endmodule
`default_nettype wire

// *** logic/rcm_top.sv ***
// Purpose: Four reference monitors with registers and lock mode control.
// Assumes: Register port strobes one cycle, read data next cycle.
// Notes: Mode outputs steer the loop outside this block.
//
// Chosen here: the register addresses and the strobed register port.
`default_nettype none
module rcm_top
  import rcm_pkg::*;
#(
  parameter int NREF = 4
)
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [NREF-1:0] ref_i,
  input wire rcm_pkg::rcm_bus_s bus_i,
  output logic [15:0] rdata_o,
  output logic limiter_bypass_o,
  output logic ref_lock_allow_o
);
  import rcm_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] loop_ctrl_q;       // Loop control
  logic [15:0] bw_ctrl_q;         // Bandwidth control
  logic [15:0] ref_chg_q;         // Reference change control
  logic [15:0] mask_q;            // Per ref: bit n single, bit n+4 multi
  logic [15:0] freq_prog_q;       // Programmed codes, 3 bits per ref
  logic [15:0] low_lim_q [NREF];  // Per-ref lower period limits
  logic [15:0] up_lim_q [NREF];   // Per-ref upper period limits
  logic [31:0] tb_q [NREF];       // Per-ref time base counts
  logic [31:0] lim_q [4];         // nu, fu, nl, fl
  logic [15:0] rdata_q;
  logic [NREF-1:0] fail_q;
  logic [NREF-1:0] sp_fail;
  logic [NREF-1:0] mp_fail;
  logic [NREF-1:0] rise;
  rcm_freq_e det_freq [NREF];
  logic [15:0] freq_stat_w;
  logic [15:0] rd_mux_w;
  // Mode bits
  wire lim_en_w = loop_ctrl_q[RCM_LIM_EN_BIT];
  wire ovr_en_w = loop_ctrl_q[RCM_FREQ_OVR_BIT];
  wire fast_w = bw_ctrl_q[RCM_FAST_BIT];
  wire semi_w = loop_ctrl_q[RCM_SEMI_FAST_BIT];
  wire freerun_w = ref_chg_q[RCM_FREERUN_BIT];
  // Semi-fast never bypasses; only the fast bit does
  assign limiter_bypass_o = fast_w; // [RQ19] [RQ20]
  // Freerun blocks locking to any reference
  assign ref_lock_allow_o = ~freerun_w; // [RQ21]
  assign rdata_o = rdata_q;
  // Address decode
  wire [7:0] a_w = bus_i.addr;
  wire in_low_w = (a_w >= RCM_LOW_BASE) && (a_w < RCM_UPP_BASE);
  wire in_up_w = (a_w >= RCM_UPP_BASE) && (a_w < RCM_TB_BASE);
  wire in_tb_w = (a_w >= RCM_TB_BASE) && (a_w < RCM_LIM_BASE);
  wire in_lim_w = (a_w >= RCM_LIM_BASE) && (a_w < RCM_LIM_BASE + 8'h08);
  wire [1:0] ri_w = a_w[1:0];
  wire [1:0] ti_w = a_w[2:1];
  wire hi_w = a_w[0];
  wire [1:0] li_w = a_w[2:1];
  ////////////////////////////////////////////////////////////////////////
  // Per-reference monitors
  genvar g;
  generate
    for (g = 0; g < NREF; g++)
    begin : g_ref
      rcm_freq_e f_w;
      // Active frequency: programmed or detected
      assign f_w = ovr_en_w ? rcm_freq_e'(freq_prog_q[3*g +: 3]) : det_freq[g]; // [RQ23]
      rcm_period_chk u_per (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .ref_i(ref_i[g]),
        .low_lim_i(low_lim_q[g]),
        .up_lim_i(up_lim_q[g]),
        .rise_o(rise[g]),
        .fail_o(sp_fail[g]),
        .freq_o(det_freq[g])
      );
      // Built-in values replace programmed ones unless enabled
      rcm_multi_chk u_mp (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .rise_i(rise[g]),
        .tb_i(lim_en_w ? tb_q[g] : tb_default(f_w)), // [RQ16]
        .near_up_i(lim_en_w ? lim_q[0] : RCM_S3_NEAR_UP), // [RQ15] [RQ16]
        .far_up_i(lim_en_w ? lim_q[1] : RCM_S3_FAR_UP),
        .near_lo_i(lim_en_w ? lim_q[2] : RCM_S3_NEAR_LO),
        .far_lo_i(lim_en_w ? lim_q[3] : RCM_S3_FAR_LO),
        .fail_o(mp_fail[g])
      );
    end
  endgenerate
  // Ten seconds of reference cycles for each rate
  function automatic logic [31:0] tb_default(input rcm_freq_e f);
    case (f)
      RCM_F1544: tb_default = 32'd15440000;
      RCM_F2048: tb_default = 32'd20480000;
      RCM_F4096: tb_default = 32'd40960000;
      RCM_F8192: tb_default = 32'd81920000;
      RCM_F16384: tb_default = 32'd163840000;
      RCM_F1944: tb_default = 32'd194400000;
      default: tb_default = RCM_TB_DEFAULT; // [RQ14]
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // Unmasked failures combine into status
  wire [NREF-1:0] fail_w = (sp_fail & ~mask_q[NREF-1:0]) |
                           (mp_fail & ~mask_q[2*NREF-1:NREF]); // [RQ2] [RQ24]
  // Status and frequency readback
  always_comb
  begin
    freq_stat_w = 16'h0000;
    for (int i = 0; i < NREF; i++)
      freq_stat_w[3*i +: 3] = det_freq[i];
  end
  assign rd_mux_w = (a_w == RCM_LOOP_CTRL) ? loop_ctrl_q :
                    (a_w == RCM_BW_CTRL) ? bw_ctrl_q :
                    (a_w == RCM_REF_CHG) ? ref_chg_q :
                    (a_w == RCM_STATUS) ? {12'h000, fail_q} :
                    (a_w == RCM_MASK) ? mask_q :
                    (a_w == RCM_FREQ_PROG) ? freq_prog_q :
                    (a_w == RCM_FREQ_STAT) ? freq_stat_w :
                    in_low_w ? low_lim_q[ri_w] :
                    in_up_w ? up_lim_q[ri_w] :
                    in_tb_w ? (hi_w ? tb_q[ti_w][31:16] : tb_q[ti_w][15:0]) :
                    in_lim_w ? (hi_w ? lim_q[li_w][31:16] : lim_q[li_w][15:0]) :
                    16'h0000;
  ////////////////////////////////////////////////////////////////////////
  // Status and read data
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      fail_q <= '0;
      rdata_q <= 16'h0000;
    end
    else
    begin
      fail_q <= fail_w; // [RQ24]
      rdata_q <= bus_i.rd ? rd_mux_w : 16'h0000;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Control register writes
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      loop_ctrl_q <= 16'h0000;
      bw_ctrl_q <= 16'h0000;
      ref_chg_q <= 16'h0000;
      mask_q <= 16'h0000;
      freq_prog_q <= 16'h0000;
    end
    else if (bus_i.wr)
    begin
      case (a_w)
        RCM_LOOP_CTRL: loop_ctrl_q <= bus_i.wdata;
        RCM_BW_CTRL: bw_ctrl_q <= bus_i.wdata;
        RCM_REF_CHG: ref_chg_q <= bus_i.wdata;
        RCM_MASK: mask_q <= bus_i.wdata; // [RQ2]
        RCM_FREQ_PROG: freq_prog_q <= bus_i.wdata;
        default: mask_q <= mask_q;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Limit register writes, 8 kHz defaults
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int i = 0; i < NREF; i++)
      begin
        low_lim_q[i] <= RCM_LO_8K; // [RQ4] [RQ5]
        up_lim_q[i] <= RCM_UP_8K;
        tb_q[i] <= RCM_TB_DEFAULT; // [RQ14]
      end
      lim_q[0] <= RCM_S3_NEAR_UP; // [RQ15]
      lim_q[1] <= RCM_S3_FAR_UP;
      lim_q[2] <= RCM_S3_NEAR_LO;
      lim_q[3] <= RCM_S3_FAR_LO;
    end
    else if (bus_i.wr)
    begin
      if (in_low_w)
        low_lim_q[ri_w] <= bus_i.wdata; // [RQ4]
      if (in_up_w)
        up_lim_q[ri_w] <= bus_i.wdata;
      if (in_tb_w && hi_w)
        tb_q[ti_w][31:16] <= bus_i.wdata; // [RQ13]
      if (in_tb_w && !hi_w)
        tb_q[ti_w][15:0] <= bus_i.wdata;
      if (in_lim_w && hi_w)
        lim_q[li_w][31:16] <= bus_i.wdata;
      if (in_lim_w && !hi_w)
        lim_q[li_w][15:0] <= bus_i.wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_mask_hides: assert property (@(posedge clock_i) disable iff (!nrst_i) // [RQ2]
    (&mask_q[2*NREF-1:0]) |=> (fail_q == '0))
    else $error("masked check reached status");
  a_fail_follow: assert property (@(posedge clock_i) disable iff (!nrst_i) // [RQ24]
    1'b1 |=> (fail_q == $past(fail_w)))
    else $error("status does not follow checks");
  a_read_data: assert property (@(posedge clock_i) disable iff (!nrst_i) // [RQ2]
    bus_i.rd && a_w == RCM_STATUS |=> rdata_q == {12'h000, $past(fail_w, 2)})
    else $error("status read wrong");
  a_bypass_fast: assert property (@(posedge clock_i) disable iff (!nrst_i) // [RQ20]
    semi_w && !fast_w |-> !limiter_bypass_o)
    else $error("semi-fast bypassed limiter");
  a_freerun: assert property (@(posedge clock_i) disable iff (!nrst_i) // [RQ21]
    freerun_w |-> !ref_lock_allow_o)
    else $error("freerun allowed lock");
endmodule
`default_nettype wire

// *** dv/rcm_ref_model.sv ***
// Purpose: Four reference clock sources facing the monitor.
// Assumes: Periods given in clock_i cycles; a period of zero holds the line low.
// Notes: Edges land just after a rising clock edge, as a synchronised input would.
`default_nettype none
module rcm_ref_model
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [63:0] period_i,
  output logic [3:0] ref_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_q [4]; // Phase counter per source
  ////////////////////////////////////////////////////////////////////////
  // Period counter, line high in the first half; a new period takes effect at once
  always @(posedge clock_i or negedge nrst_i)
  begin
    for (int n = 0; n < 4; n++)
    begin
      if (!nrst_i || period_i[16*n +: 16] == 16'h0000)
      begin
        cnt_q[n] <= 16'h0000;
        ref_o[n] <= 1'b0;
      end
      else
      begin
        cnt_q[n] <= (cnt_q[n] >= period_i[16*n +: 16] - 16'h0001) ? 16'h0000 :
          cnt_q[n] + 16'h0001;
        ref_o[n] <= (cnt_q[n] < (period_i[16*n +: 16] >> 1));
      end
    end
  end
endmodule
`default_nettype wire

// *** dv/rcm_top_tb_top.sv ***
// Purpose: Self-checking bench for the reference clock monitor.
// Assumes: Small time base programmed with the limit enable set, to keep runs short.
// Notes: Status bit n is the combined fail of reference n after masking.
`default_nettype none
module rcm_top_tb_top;
  import rcm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] NU = 32'h012c; // Near upper, 300 clocks
  localparam logic [31:0] FU = 32'h0118; // Far upper, 280 clocks
  localparam logic [31:0] NL = 32'h0154; // Near lower, 340 clocks
  localparam logic [31:0] FL = 32'h0168; // Far lower, 360 clocks
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  rcm_bus_s bus = '0; // Register port request
  logic [63:0] period = '0; // Source periods, all still at start
  logic [3:0] refs;
  logic [15:0] rdata;
  logic bypass;
  logic allow;
  logic [15:0] rnd [16:39]; // Random register images
  logic [31:0] s3 [4] = '{RCM_S3_NEAR_UP, RCM_S3_FAR_UP, RCM_S3_NEAR_LO, RCM_S3_FAR_LO};
  logic [3:0] ms; // Expected multi-period fails
  int err_total = 0;
  int total_checks = 0;
  always #5 clock_i = ~clock_i;
  rcm_top #(.NREF(4)) dut (.clock_i(clock_i), .nrst_i(nrst_i), .ref_i(refs), .bus_i(bus),
    .rdata_o(rdata), .limiter_bypass_o(bypass), .ref_lock_allow_o(allow));
  rcm_ref_model src (.clock_i(clock_i), .nrst_i(nrst_i), .period_i(period), .ref_o(refs));
  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_i);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clock_i);
    bus.wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string m);
    @(posedge clock_i);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clock_i);
    bus.rd <= 1'b0;
    #1 chk_word(rdata, exp, m);
  endtask
  // Write a mode register, then look at the two mode outputs
  task automatic mode(input logic [7:0] a, input logic [15:0] d, input logic eb, input logic ea);
    wr(a, d);
    #1 chk_bit(bypass, eb, "limiter bypass");
    chk_bit(allow, ea, "lock allow");
  endtask
  task automatic set_periods(input logic [63:0] p);
    @(posedge clock_i);
    period <= p;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Expected outcomes
  function automatic logic single_fail(input logic [15:0] p, input logic [15:0] up,
    input logic [15:0] lo);
    return (p < up) || (p > lo);
  endfunction
  // Hysteresis over a 16-cycle time base; the grey zone keeps the old state
  function automatic logic multi_next(input logic prev, input logic [15:0] p);
    logic [31:0] c;
    c = 32'(p) * 32'd16;
    if (c < FU || c > FL)
      return 1'b1;
    if (c >= NU && c <= NL)
      return 1'b0;
    return prev;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [15:0] p;
    logic [3:0] ex;
    void'($urandom(32'he443));
    repeat (12) @(posedge clock_i);
    chk_bit(bypass, 1'b0, "reset bypass");
    chk_bit(allow, 1'b1, "reset allow");
    chk_word(rdata, 16'h0000, "reset rdata");
    nrst_i <= 1'b1;
    for (int n = 0; n < 4; n++)
    begin
      rd(8'(RCM_LOW_BASE + n), RCM_LO_8K, "lower default");
      rd(8'(RCM_UPP_BASE + n), RCM_UP_8K, "upper default");
      rd(8'(RCM_TB_BASE + 2 * n), RCM_TB_DEFAULT[15:0], "tb low default");
      rd(8'(RCM_TB_BASE + 2 * n + 1), RCM_TB_DEFAULT[31:16], "tb high default");
      rd(8'(RCM_LIM_BASE + 2 * n), s3[n][15:0], "limit low default");
      rd(8'(RCM_LIM_BASE + 2 * n + 1), s3[n][31:16], "limit high default");
    end
    wr(8'h40, 16'(($urandom)));
    rd(8'h40, 16'h0000, "unmapped");
    mode(RCM_LOOP_CTRL, 16'h0008, 1'b0, 1'b1);
    mode(RCM_BW_CTRL, 16'h2000, 1'b1, 1'b1);
    mode(RCM_BW_CTRL, 16'h0000, 1'b0, 1'b1);
    // Freerun only once fast lock is off again, never both together
    mode(RCM_REF_CHG, 16'h0001, 1'b0, 1'b0);
    mode(RCM_REF_CHG, 16'h0000, 1'b0, 1'b1);
    // Random images for every limit and count register
    for (int a = 16; a < 40; a++)
    begin
      rnd[a] = 16'($urandom);
      wr(8'(a), rnd[a]);
    end
    for (int a = 16; a < 40; a++)
      rd(8'(a), rnd[a], "readback");
    // Functional setup: short time base, programmed limits, limit enable on
    for (int n = 0; n < 4; n++)
    begin
      wr(8'(RCM_TB_BASE + 2 * n), 16'h0010);
      wr(8'(RCM_TB_BASE + 2 * n + 1), 16'h0000);
      wr(8'(RCM_LIM_BASE + 2 * n), 16'({NU, FU, NL, FL} >> (96 - 32 * n)));
      wr(8'(RCM_LIM_BASE + 2 * n + 1), 16'h0000);
      wr(8'(RCM_LOW_BASE + n), 16'h0030);
      wr(8'(RCM_UPP_BASE + n), 16'h0010);
    end
    wr(RCM_LOOP_CTRL, 16'h0004);
    wr(RCM_MASK, 16'h00f0);
    // Single period: boundary case first, then random periods
    for (int r = 0; r < 3; r++)
    begin
      for (int n = 0; n < 4; n++)
      begin
        p = (r == 0) ? 16'(64'h0030003c000c0010 >> (16 * n)) : 16'(8 + $urandom % 60);
        period[16*n +: 16] <= p;
        ex[n] = single_fail(p, 16'h0010, 16'h0030);
      end
      repeat (600) @(posedge clock_i);
      rd(RCM_STATUS, {12'h000, ex}, "single status");
    end
    wr(RCM_MASK, 16'h00ff);
    rd(RCM_STATUS, 16'h0000, "all masked");
    // Multi period with hysteresis
    wr(RCM_MASK, 16'h000f);
    set_periods(64'h0014001400140014);
    repeat (1600) @(posedge clock_i);
    rd(RCM_STATUS, 16'h0000, "multi settle");
    set_periods(64'h0011001600180014);
    ms = {multi_next(1'b0, 16'h0011), multi_next(1'b0, 16'h0016),
      multi_next(1'b0, 16'h0018), multi_next(1'b0, 16'h0014)};
    repeat (1600) @(posedge clock_i);
    rd(RCM_STATUS, {12'h000, ms}, "multi fail");
    set_periods(64'h0013001600160014);
    ms = {multi_next(ms[3], 16'h0013), multi_next(ms[2], 16'h0016),
      multi_next(ms[1], 16'h0016), multi_next(ms[0], 16'h0014)};
    repeat (1600) @(posedge clock_i);
    rd(RCM_STATUS, {12'h000, ms}, "grey hold");
    set_periods(64'h0013001600160018);
    repeat (300) @(posedge clock_i);
    rd(RCM_STATUS, {12'h000, ms}, "one measurement");
    ms[0] = multi_next(ms[0], 16'h0018);
    repeat (1600) @(posedge clock_i);
    rd(RCM_STATUS, {12'h000, ms}, "two measurements");
    // Periods of 19 to 24 clocks fall inside the 4.096 MHz detect window, above the 8.192 MHz one
    rd(RCM_FREQ_STAT, {4'h0, RCM_F4096, RCM_F4096, RCM_F4096, RCM_F4096}, "rate");
    // Lost reference: line held low until the period counter saturates
    wr(RCM_MASK, 16'h00f0);
    set_periods(64'h0013001600160000);
    repeat (65600) @(posedge clock_i);
    rd(RCM_STATUS, 16'h0001, "lost reference");
    rd(RCM_FREQ_STAT, {4'h0, RCM_F4096, RCM_F4096, RCM_F4096, RCM_FNONE}, "no rate");
    close_out();
  end
  // Watchdog past the expected run of about 74400 cycles, loss wait included
  initial
  begin
    #900us;
    err_total++;
    $display("MISMATCH %0t watchdog expired", $time);
    close_out();
  end
endmodule
`default_nettype wire
